// ### bridge_arb_cfg.svh
// Offsets, field positions, reset values and timing counts for the bridge arbitration block.
`ifndef BRIDGE_ARB_CFG_SVH
`define BRIDGE_ARB_CFG_SVH

`define ARB_NUM_MASTERS 10
`define ARB_BRIDGE_IDX 4'h9
`define ARB_LOW_SLOT 4'hA
`define ARB_HI_SLOTS 11
`define ARB_PRIO_OFFSET 8'h00
`define ARB_STATUS_OFFSET 8'h04
`define ARB_PRIO_RESET 10'h200
`define ST_GNT_IDX_LSB 0
`define ST_GNT_ON_BIT 4
`define ST_EXT_MODE_BIT 5
`define ST_P_REQ_BIT 6
`define ST_P_PARK_BIT 7
`define ST_S_PARK_BIT 8
`define P_BACKOFF_CYCLES 2'h2
`define POST_REQ_DELAY 2'h3
`define S_GNT_TIMEOUT 5'h10

`endif

// ### bridge_arb_pkg.sv
// Types shared by the bridge arbitration block.
package bridge_arb_pkg;

    typedef logic [3:0] master_idx_t;

    typedef enum logic {
        GNT_HOLD,
        GNT_GAP
    } sec_gnt_state_t;

endpackage

// ### pci_bridge_bus_arbitration.sv
// Primary request/park and secondary two-level arbiter with parking for a PCI bridge.
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "bridge_arb_cfg.svh"

// Contract
// - Primary request stays asserted while upstream posted or delayed work is pending.
// - After retry, disconnect or abort, drop primary request for two clocks; the code holds it high for three.
// - Posted write raises primary request a few clocks after device select.
// - Delayed request waits until fully queued, retried, and at queue head.
// - Primary grant while requesting starts the transaction next clock.
// - Park primary only with grant, no own request, and idle bus.
// - Parked with work to start, assert frame next clock if grant was held.
// - Primary grant removed releases address, command and parity drivers next clock.
// - Parking drives address and command first, parity one clock later.
// - Strap low: internal arbiter for nine external masters plus the bridge.
// - Low group is one slot of the high rotation, rotating evenly inside.
// - Per-master priority bit, 1 high, 0 low; one group means round-robin.
// - After reset all externals low, bridge alone in the high group.
// - Priorities re-evaluated at frame; highest asserted request gets the grant.
// - Previous initiator becomes lowest in its group, its follower highest.
// - Withdraw grant after 16 idle granted clocks with no frame.
// - Idle bus needs one clock gap between grants; busy bus may switch.
// - Strap high: grant output 0 is bridge request, request input 0 its grant.
// - External mode: start the secondary transaction one clock after grant.
// - External mode drives grants 8:1 high; board pulls requests 8:1 high.
// - Internal mode parks at last master; after reset parks at the bridge.
// - External mode parks secondary only with grant, no request, idle bus.
module pci_bridge_bus_arbitration (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Upstream queue indications
    input wire logic up_posted_pending,
    input wire logic up_delayed_head_ready,
    input wire logic p_target_term,
    // Downstream queue indication
    input wire logic down_request,
    // Primary bus pins
    output logic primary_req_n,
    input wire logic primary_gnt_n,
    input wire logic primary_frame_n,
    input wire logic primary_irdy_n,
    output logic [31:0] primary_ad_o,
    output logic primary_ad_oe,
    output logic [3:0] primary_cmd_byte_enable_n_o,
    output logic primary_parity_o,
    output logic primary_parity_oe,
    output logic p_start,
    // Secondary bus pins
    input wire logic internal_arbiter_select_strap_n,
    input wire logic [8:0] secondary_req_n,
    output logic [8:0] secondary_gnt_n,
    input wire logic secondary_frame_n,
    input wire logic secondary_initiator_ready_n,
    output logic [31:0] secondary_ad_o,
    output logic secondary_ad_oe,
    output logic [3:0] secondary_cmd_byte_enable_n_o,
    output logic secondary_parity_o,
    output logic secondary_parity_oe,
    output logic s_start
);

    localparam int NPIN = 15;

    // Low group as one slot: high rotation over 10 masters plus the low slot.
    function automatic logic [4:0] pick(input logic [9:0] req, input logic [9:0] prio,
                                        input logic [3:0] last_hi, input logic [3:0] last_lo);
        logic [4:0] res;
        logic lo_any;
        logic hit;
        logic [3:0] j;
        logic cand;
        res = 5'h00;
        lo_any = |(req & ~prio);
        hit = 1'b0;
        for (int k = 1; k <= `ARB_HI_SLOTS; k++) begin
            j = 4'((int'(last_hi) + k) % `ARB_HI_SLOTS);
            cand = (j == `ARB_LOW_SLOT) ? lo_any : (req[j] & prio[j]);
            if (!hit && cand) begin
                hit = 1'b1;
                res = {1'b1, j};
            end
        end
        if (hit && res[3:0] == `ARB_LOW_SLOT) begin
            hit = 1'b0;
            for (int k = 1; k <= `ARB_NUM_MASTERS; k++) begin
                j = 4'((int'(last_lo) + k) % `ARB_NUM_MASTERS);
                if (!hit && req[j] && !prio[j]) begin
                    hit = 1'b1;
                    res = {1'b1, j};
                end
            end
        end
        return res;
    endfunction

    // Pin inputs: three flops and a filter flop, a change counts once stages two and three agree.
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s1;
    logic [NPIN-1:0] pin_s2;
    logic [NPIN-1:0] pin_s3;
    logic [NPIN-1:0] pin_f;

    assign pin_raw = {internal_arbiter_select_strap_n, secondary_initiator_ready_n,
                      secondary_frame_n, secondary_req_n, primary_irdy_n,
                      primary_frame_n, primary_gnt_n};

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (!rst_b) begin
                    pin_s1[g] <= 1'b1;
                    pin_s2[g] <= 1'b1;
                    pin_s3[g] <= 1'b1;
                    pin_f[g] <= 1'b1;
                end else begin
                    pin_s1[g] <= pin_raw[g];
                    pin_s2[g] <= pin_s1[g];
                    pin_s3[g] <= pin_s2[g];
                    if (pin_s2[g] == pin_s3[g]) begin
                        pin_f[g] <= pin_s3[g];
                    end
                end
            end
        end
    endgenerate

    logic p_gnt;
    logic p_idle;
    logic [8:0] s_req;
    logic s_frame;
    logic s_busy;
    logic ext_mode;
    assign p_gnt = ~pin_f[0];
    assign p_idle = pin_f[1] & pin_f[2];
    assign s_req = ~pin_f[11:3];
    assign s_frame = ~pin_f[12];
    assign s_busy = ~pin_f[12] | ~pin_f[13];
    assign ext_mode = pin_f[14];

    logic [9:0] prio;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            prio <= `ARB_PRIO_RESET;
        end else if (reg_wr && reg_addr == `ARB_PRIO_OFFSET) begin
            prio <= reg_wdata[9:0];
        end
    end

    // Primary request.
    logic [1:0] post_cnt;
    logic [1:0] backoff;
    logic p_want;
    logic p_park;
    logic p_park_d;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            post_cnt <= 2'h0;
        end else if (!up_posted_pending) begin
            post_cnt <= 2'h0;
        end else if (post_cnt != `POST_REQ_DELAY) begin
            // Short delay after the posted write is accepted.
            post_cnt <= post_cnt + 2'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            backoff <= 2'h0;
        end else if (p_target_term) begin
            backoff <= `P_BACKOFF_CYCLES;
        end else if (backoff != 2'h0) begin
            backoff <= backoff - 2'h1;
        end
    end

    // Delayed work counts only at the queue head.
    assign p_want = (post_cnt == `POST_REQ_DELAY) | up_delayed_head_ready;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            primary_req_n <= 1'b1;
        end else begin
            primary_req_n <= ~(p_want && backoff == 2'h0 && !p_target_term);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            p_start <= 1'b0;
        end else begin
            // Parked start needs the grant in the previous clock.
            p_start <= ~primary_req_n & p_gnt & p_idle & ~p_start;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            p_park <= 1'b0;
            p_park_d <= 1'b0;
        end else begin
            // Grant removal releases on the next clock.
            p_park <= p_gnt & primary_req_n & p_idle;
            p_park_d <= p_park;
        end
    end

    assign primary_ad_oe = p_park;
    assign primary_ad_o = 32'h00000000;
    assign primary_cmd_byte_enable_n_o = 4'h0;
    // Parity enable trails by a clock.
    assign primary_parity_oe = p_park & p_park_d;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            primary_parity_o <= 1'b0;
        end else begin
            // Even parity of last clock's drive.
            primary_parity_o <= ^{primary_ad_o, primary_cmd_byte_enable_n_o};
        end
    end

    // Secondary internal arbiter.
    bridge_arb_pkg::master_idx_t cur;
    bridge_arb_pkg::master_idx_t last_hi;
    bridge_arb_pkg::master_idx_t last_lo;
    bridge_arb_pkg::sec_gnt_state_t gstate;
    logic gnt_on;
    logic frame_d;
    logic [4:0] idle_cnt;
    logic [9:0] all_req;
    logic [4:0] win;
    logic frame_rise;
    logic timeout;

    // Nine external requests plus the bridge.
    assign all_req = {down_request, s_req};
    assign win = pick(all_req, prio, last_hi, last_lo);
    assign frame_rise = s_frame & ~frame_d;
    assign timeout = gnt_on && idle_cnt == `S_GNT_TIMEOUT;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            frame_d <= 1'b0;
        end else begin
            frame_d <= s_frame;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b || !gnt_on || s_busy || !all_req[cur]) begin
            idle_cnt <= 5'h00;
        end else if (idle_cnt != `S_GNT_TIMEOUT) begin
            idle_cnt <= idle_cnt + 5'h01;
        end
    end

    // Rotation pointers move at each new frame; a timed-out master is treated as served,
    // so the same request wins the very next evaluation only when no other request is asserted.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            last_hi <= `ARB_BRIDGE_IDX;
            last_lo <= `ARB_BRIDGE_IDX;
        end else if ((frame_rise || timeout) && !ext_mode) begin
            // Initiator drops to last in its group.
            if (prio[cur]) begin
                last_hi <= cur;
            end else begin
                last_hi <= `ARB_LOW_SLOT;
                last_lo <= cur;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            // Parked at the bridge after reset.
            cur <= `ARB_BRIDGE_IDX;
            gnt_on <= 1'b1;
            gstate <= bridge_arb_pkg::GNT_HOLD;
        end else begin
            unique case (gstate)
                bridge_arb_pkg::GNT_HOLD: begin
                    if (timeout) begin
                        gnt_on <= 1'b0;
                        gstate <= bridge_arb_pkg::GNT_GAP;
                    end else if (win[4] && (win[3:0] != cur || !gnt_on)) begin
                        if (s_busy && gnt_on) begin
                            // Busy bus switches in one clock.
                            cur <= win[3:0];
                        end else begin
                            // Idle bus leaves a dead clock.
                            gnt_on <= 1'b0;
                            gstate <= bridge_arb_pkg::GNT_GAP;
                        end
                    end
                end
                bridge_arb_pkg::GNT_GAP: begin
                    // Without requests the last owner keeps the park.
                    if (win[4]) begin
                        cur <= win[3:0];
                    end
                    gnt_on <= 1'b1;
                    gstate <= bridge_arb_pkg::GNT_HOLD;
                end
            endcase
        end
    end

    logic own_gnt;
    logic s_park;
    logic s_park_d;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            secondary_gnt_n <= 9'h1FF;
        end else if (ext_mode) begin
            // Grant 0 becomes the bridge request.
            secondary_gnt_n <= {8'hFF, ~down_request};
        end else begin
            for (int i = 0; i < 9; i++) begin
                secondary_gnt_n[i] <= ~(gnt_on && cur == 4'(i));
            end
        end
    end

    // Request input 0 becomes the bridge grant.
    assign own_gnt = ext_mode ? s_req[0] : (gnt_on && cur == `ARB_BRIDGE_IDX);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s_start <= 1'b0;
        end else begin
            // Start one clock after the grant.
            s_start <= down_request & own_gnt & ~s_busy & ~s_start &
                       (ext_mode ? ~secondary_gnt_n[0] : 1'b1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s_park <= 1'b0;
            s_park_d <= 1'b0;
        end else begin
            // Park only with grant, no request, idle bus.
            s_park <= own_gnt & ~down_request & ~s_busy;
            s_park_d <= s_park;
        end
    end

    assign secondary_ad_oe = s_park;
    assign secondary_ad_o = 32'h00000000;
    assign secondary_cmd_byte_enable_n_o = 4'h0;
    // Parity enable trails by a clock.
    assign secondary_parity_oe = s_park & s_park_d;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            secondary_parity_o <= 1'b0;
        end else begin
            // Even parity of last clock's drive.
            secondary_parity_o <= ^{secondary_ad_o, secondary_cmd_byte_enable_n_o};
        end
    end

    // Read data: one cycle after the read strobe, zero for unmapped addresses.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd && reg_addr == `ARB_PRIO_OFFSET) begin
            reg_rdata <= {22'h000000, prio};
        end else if (reg_rd && reg_addr == `ARB_STATUS_OFFSET) begin
            reg_rdata <= 32'h00000000;
            reg_rdata[`ST_GNT_IDX_LSB +: 4] <= cur;
            reg_rdata[`ST_GNT_ON_BIT] <= gnt_on;
            reg_rdata[`ST_EXT_MODE_BIT] <= ext_mode;
            reg_rdata[`ST_P_REQ_BIT] <= ~primary_req_n;
            reg_rdata[`ST_P_PARK_BIT] <= p_park;
            reg_rdata[`ST_S_PARK_BIT] <= s_park;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule

// ### pci_bridge_bus_arbitration_props.sv
// Checker that watches the ports of the bridge arbitration block.
`timescale 1ns/1ps
module pci_bridge_bus_arbitration_props (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Register port and queues
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic up_posted_pending,
    input wire logic up_delayed_head_ready,
    input wire logic p_target_term,
    input wire logic down_request,
    // Primary pins
    input wire logic primary_req_n,
    input wire logic [31:0] primary_ad_o,
    input wire logic primary_ad_oe,
    input wire logic [3:0] primary_cmd_byte_enable_n_o,
    input wire logic primary_parity_o,
    input wire logic primary_parity_oe,
    input wire logic p_start,
    // Secondary pins
    input wire logic internal_arbiter_select_strap_n,
    input wire logic [8:0] secondary_req_n,
    input wire logic [8:0] secondary_gnt_n,
    input wire logic secondary_frame_n,
    input wire logic secondary_initiator_ready_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic [2:0] idle_cnt;
    logic [4:0] hold_cnt;
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !secondary_frame_n || !secondary_initiator_ready_n) begin
            idle_cnt <= 3'h0;
        end else if (idle_cnt != 3'h7) begin
            idle_cnt <= idle_cnt + 3'h1;
        end
    end
    // Counts idle clocks in which one requesting pin keeps its grant.
    always_ff @(posedge sys_clk) begin
        if (!rst_b || secondary_gnt_n != $past(secondary_gnt_n) || idle_cnt != 3'h7
            || &(secondary_gnt_n | secondary_req_n)) begin
            hold_cnt <= 5'h0;
        end else if (hold_cnt != 5'h1F) begin
            hold_cnt <= hold_cnt + 5'h1;
        end
    end
    chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    chk_backoff_two: assert property (p_target_term |=> primary_req_n [*2])
        else $error("request back too soon");
    chk_request_held: assert property (!primary_req_n && !p_target_term
        && (up_posted_pending || up_delayed_head_ready) |=> !primary_req_n)
        else $error("request dropped with work pending");
    chk_park_idle: assert property ($rose(primary_ad_oe) |-> $past(primary_req_n))
        else $error("parking while requesting");
    chk_parity_late: assert property (primary_parity_oe |-> primary_ad_oe && $past(primary_ad_oe))
        else $error("parity driven out of order");
    chk_parity_even: assert property (primary_parity_oe |-> primary_parity_o ==
        ^{$past(primary_ad_o), $past(primary_cmd_byte_enable_n_o)})
        else $error("parked parity wrong");
    chk_start_once: assert property (p_start |->
        (!$past(primary_req_n) || $past(primary_ad_oe)) ##1 !p_start)
        else $error("start without request");
    chk_ext_grants: assert property (internal_arbiter_select_strap_n
        && $past(internal_arbiter_select_strap_n, 4) |-> &secondary_gnt_n[8:1])
        else $error("unused grant driven low");
    chk_ext_request: assert property (internal_arbiter_select_strap_n
        && $past(internal_arbiter_select_strap_n, 4) && $stable(down_request)
        |-> secondary_gnt_n[0] == !down_request)
        else $error("external request wrong");
    chk_idle_gap: assert property (idle_cnt == 3'h7 && $past(secondary_gnt_n) != 9'h1FF
        && secondary_gnt_n != $past(secondary_gnt_n) |-> secondary_gnt_n == 9'h1FF)
        else $error("grant switched on idle bus");
    chk_one_grant: assert property (!internal_arbiter_select_strap_n
        |-> $onehot0(~secondary_gnt_n))
        else $error("two grants at once");
    chk_grant_timeout: assert property (hold_cnt <= 5'h18)
        else $error("unused grant never withdrawn");
endmodule
bind pci_bridge_bus_arbitration pci_bridge_bus_arbitration_props u_props (
    .sys_clk, .rst_b, .reg_rd, .reg_rdata, .up_posted_pending, .up_delayed_head_ready,
    .p_target_term, .down_request, .primary_req_n, .primary_ad_o, .primary_ad_oe,
    .primary_cmd_byte_enable_n_o, .primary_parity_o, .primary_parity_oe, .p_start,
    .internal_arbiter_select_strap_n, .secondary_req_n, .secondary_gnt_n,
    .secondary_frame_n, .secondary_initiator_ready_n
);

// ### pri_arbiter_model.sv
// Model of the primary bus arbiter and of the primary bus it watches.
`timescale 1ns/1ps
module pri_arbiter_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Bridge side
    input wire logic primary_req_n,
    input wire logic p_start,
    input wire logic park_here,
    // Bus side
    output logic primary_gnt_n,
    output logic primary_frame_n,
    output logic primary_irdy_n
);
    logic grant_soon;
    logic [1:0] busy;
    // Grant two clocks late, to a request or to park.
    always_ff @(posedge sys_clk) begin
        grant_soon <= rst_b && (!primary_req_n || park_here);
        primary_gnt_n <= !grant_soon;
    end
    // The started transaction keeps the bus busy briefly.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            busy <= 2'h0;
        end else if (p_start) begin
            busy <= 2'h2;
        end else if (busy != 2'h0) begin
            busy <= busy - 2'h1;
        end
    end
    assign primary_frame_n = busy != 2'h2;
    assign primary_irdy_n = busy == 2'h0;
endmodule

// ### pci_bridge_bus_arbitration_tb.sv
// Directed testbench for the bridge arbitration block.
`timescale 1ns/1ps
module pci_bridge_bus_arbitration_tb;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic up_posted_pending = 1'b0;
    logic up_delayed_head_ready = 1'b0;
    logic p_target_term = 1'b0;
    logic down_request = 1'b0;
    logic internal_arbiter_select_strap_n = 1'b0;
    logic [8:0] secondary_req_n = 9'h1FF;
    logic secondary_frame_n = 1'b1;
    logic secondary_initiator_ready_n = 1'b1;
    logic park_here = 1'b0;
    logic [31:0] reg_rdata, primary_ad_o, secondary_ad_o, rd;
    logic [3:0] primary_cmd_byte_enable_n_o, secondary_cmd_byte_enable_n_o;
    logic [8:0] secondary_gnt_n, want_gnt, first;
    logic primary_req_n, primary_gnt_n, primary_frame_n, primary_irdy_n, p_start, s_start;
    logic primary_ad_oe, primary_parity_o, primary_parity_oe;
    logic secondary_ad_oe, secondary_parity_o, secondary_parity_oe;
    int n_fail = 0;
    int comparisons = 0;
    always #2 sys_clk = ~sys_clk;
    pci_bridge_bus_arbitration u_pci_bridge_bus_arbitration (
        .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .up_posted_pending(up_posted_pending), .up_delayed_head_ready(up_delayed_head_ready),
        .p_target_term(p_target_term), .down_request(down_request),
        .primary_req_n(primary_req_n), .primary_gnt_n(primary_gnt_n),
        .primary_frame_n(primary_frame_n), .primary_irdy_n(primary_irdy_n),
        .primary_ad_o(primary_ad_o), .primary_ad_oe(primary_ad_oe),
        .primary_cmd_byte_enable_n_o(primary_cmd_byte_enable_n_o),
        .primary_parity_o(primary_parity_o), .primary_parity_oe(primary_parity_oe),
        .p_start(p_start), .internal_arbiter_select_strap_n(internal_arbiter_select_strap_n),
        .secondary_req_n(secondary_req_n), .secondary_gnt_n(secondary_gnt_n),
        .secondary_frame_n(secondary_frame_n),
        .secondary_initiator_ready_n(secondary_initiator_ready_n),
        .secondary_ad_o(secondary_ad_o), .secondary_ad_oe(secondary_ad_oe),
        .secondary_cmd_byte_enable_n_o(secondary_cmd_byte_enable_n_o),
        .secondary_parity_o(secondary_parity_o), .secondary_parity_oe(secondary_parity_oe),
        .s_start(s_start)
    );
    pri_arbiter_model u_pri_arbiter_model (
        .sys_clk(sys_clk), .rst_b(rst_b), .primary_req_n(primary_req_n), .p_start(p_start),
        .park_here(park_here), .primary_gnt_n(primary_gnt_n),
        .primary_frame_n(primary_frame_n), .primary_irdy_n(primary_irdy_n)
    );
    function automatic logic probe(input int sel);
        case (sel)
            0: return primary_req_n;
            1: return p_start;
            2: return primary_ad_oe;
            3: return s_start;
            4: return secondary_ad_oe;
            5: return secondary_gnt_n === want_gnt;
            default: return (secondary_gnt_n & 9'h00A) !== 9'h00A;
        endcase
    endfunction
    task automatic print_verdict();
        $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic wait_on(input int sel, input logic v, input int n, input string m);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < n && !hit; i++) begin
            @(posedge sys_clk);
            #1;
            hit = probe(sel) === v;
        end
        comparisons++;
        if (!hit) begin
            n_fail++;
            $display("CHECK FAILED at %0t: timeout %s", $time, m);
            print_verdict();
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic do_reset(input logic s);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        internal_arbiter_select_strap_n <= s;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge sys_clk);
    endtask
    initial begin
        do_reset(1'b0);
        reg_read(8'h00, rd);
        check(rd, 32'h200, "priority reset value");
        reg_read(8'h04, rd);
        check(rd & 32'h3F, 32'h19, "status after reset");
        check({23'h0, secondary_gnt_n}, 32'h1FF, "no pin granted");
        reg_write(8'h08, 32'hFFFF_FFFF);
        reg_read(8'h08, rd);
        check(rd, 32'h0, "unmapped read");
        $display("test reset done");
        check({31'h0, primary_req_n}, 32'h1, "no request when idle");
        @(posedge sys_clk) up_delayed_head_ready <= 1'b1;
        wait_on(0, 1'b0, 4, "delayed request");
        wait_on(1, 1'b1, 20, "primary start");
        @(posedge sys_clk) p_target_term <= 1'b1;
        @(posedge sys_clk) p_target_term <= 1'b0;
        wait_on(0, 1'b0, 10, "request after backoff");
        @(posedge sys_clk) up_delayed_head_ready <= 1'b0;
        wait_on(0, 1'b1, 8, "request released");
        @(posedge sys_clk) up_posted_pending <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        check({31'h0, primary_req_n}, 32'h1, "posted request waits");
        wait_on(0, 1'b0, 6, "posted request");
        @(posedge sys_clk) up_posted_pending <= 1'b0;
        wait_on(0, 1'b1, 8, "posted released");
        $display("test primary request done");
        @(posedge sys_clk) park_here <= 1'b1;
        wait_on(2, 1'b1, 12, "primary park");
        @(posedge sys_clk);
        #1;
        check({31'h0, primary_parity_oe}, 32'h1, "parity one clock later");
        check({31'h0, primary_parity_o}, 32'h0, "even parity of zero");
        @(posedge sys_clk) up_delayed_head_ready <= 1'b1;
        wait_on(1, 1'b1, 10, "start from park");
        @(posedge sys_clk) up_delayed_head_ready <= 1'b0;
        park_here <= 1'b0;
        wait_on(2, 1'b0, 12, "park released");
        $display("test primary park done");
        want_gnt = 9'h1FB;
        @(posedge sys_clk) secondary_req_n <= 9'h1FB;
        wait_on(5, 1'b1, 12, "grant to master two");
        want_gnt = 9'h1FF;
        wait_on(5, 1'b1, 26, "unused grant withdrawn");
        @(posedge sys_clk) secondary_req_n <= 9'h1FF;
        reg_write(8'h00, 32'h0);
        @(posedge sys_clk) secondary_req_n <= 9'h1F5;
        wait_on(6, 1'b1, 16, "first grant");
        first = secondary_gnt_n;
        check({31'h0, first == 9'h1FD || first == 9'h1F7}, 32'h1, "winner requested");
        want_gnt = first ^ 9'h00A;
        @(posedge sys_clk) secondary_frame_n <= 1'b0;
        secondary_initiator_ready_n <= 1'b0;
        secondary_req_n <= 9'h1F5 | ~first;
        repeat (2) @(posedge sys_clk);
        secondary_frame_n <= 1'b1;
        @(posedge sys_clk) secondary_initiator_ready_n <= 1'b1;
        wait_on(5, 1'b1, 16, "rotated to the other");
        @(posedge sys_clk) secondary_req_n <= 9'h1FF;
        $display("test secondary internal done");
        do_reset(1'b1);
        check({24'h0, secondary_gnt_n[8:1]}, 32'hFF, "unused grants high");
        reg_read(8'h04, rd);
        check({31'h0, rd[5]}, 32'h1, "external mode shown");
        want_gnt = 9'h1FE;
        @(posedge sys_clk) down_request <= 1'b1;
        wait_on(5, 1'b1, 8, "external request");
        // Request pins 8:1 stay high as a board pull-up would hold them.
        @(posedge sys_clk) secondary_req_n <= 9'h1FE;
        wait_on(3, 1'b1, 10, "external start");
        @(posedge sys_clk) down_request <= 1'b0;
        wait_on(4, 1'b1, 10, "secondary park");
        @(posedge sys_clk);
        #1;
        check({30'h0, secondary_parity_oe, secondary_parity_o}, 32'h2, "sec parity");
        @(posedge sys_clk) secondary_req_n <= 9'h1FF;
        wait_on(4, 1'b0, 10, "secondary park released");
        $display("test secondary external done");
        print_verdict();
    end
endmodule
